// ### design/bcdadj_pkg.sv
// shared types and constants for the bcd adjust and decrement datapath
package bcdadj_pkg;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int ADDR_W = DATA_W + BANK_W;
  // fixed window bank: low half maps to bank 0, high half to the top bank
  localparam logic [7:0] WINDOW_SPLIT = 8'h80;
  localparam logic [3:0] WINDOW_LO_BANK = 4'h0;
  localparam logic [3:0] WINDOW_HI_BANK = 4'hf;
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [3:0] BCD_CORRECTION = 4'h6;
  localparam logic [7:0] SIGNED_MIN = 8'h80;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic {OP_BCD_ADJUST, OP_MINUS_ONE} bcdadj_kind_t;

  typedef struct packed {
    bcdadj_kind_t kind;
    logic to_reg;      // result target bit for minus one: 1 = data register, 0 = acc
    logic use_bank;    // bank bypass bit: 1 = pointer bank, 0 = window
    logic [7:0] addr;
  } bcdadj_instr_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } bcdadj_flags_t;

  localparam bcdadj_flags_t FLAGS_NONE = '{n: 1'b0, ov: 1'b0, z: 1'b0,
    dc: 1'b0, c: 1'b0};
  localparam bcdadj_flags_t FLAGS_ALL = '{n: 1'b1, ov: 1'b1, z: 1'b1,
    dc: 1'b1, c: 1'b1};
  localparam bcdadj_flags_t FLAGS_ADJUST = '{n: 1'b0, ov: 1'b0, z: 1'b0,
    dc: 1'b1, c: 1'b1};
  localparam bcdadj_instr_t INSTR_RESET = '{kind: OP_BCD_ADJUST,
    to_reg: 1'b0, use_bank: 1'b0, addr: 8'h00};
endpackage

// ### design/bcdadj_digit.sv
// one decimal digit correction stage
`timescale 1ns/10ps
`default_nettype none
module bcdadj_digit
  import bcdadj_pkg::*;
(
  input wire logic [4:0] digit,
  input wire logic force_fix,
  output logic fixed,
  output logic [5:0] sum
);
  // digit carries an incoming carry, so it may exceed fifteen
  always_comb
  begin
    fixed = force_fix || (digit > {1'b0, BCD_MAX_DIGIT});
    sum = {1'b0, digit} + (fixed ? {2'b00, BCD_CORRECTION} : 6'h00);
  end
endmodule // bcdadj_digit
`default_nettype wire

// ### design/bcdadj_core.sv
// four-phase datapath for decimal adjust and minus one instructions
//
// Notes on behaviour
// - decimal adjust adds 6 to low nibble if above nine or digit carry set
// - decimal adjust adds 6 to high nibble if above nine or carry set
// - decimal adjust may set carry on high overflow whatever the old carry
// - minus one subtracts one from the addressed byte, address 0 to 255
// - target bit zero writes result to accumulator, register untouched
// - target bit one writes a minus one result back into the addressed register
// - bypass bit zero addresses the fixed window bank, ignoring pointer
// - bypass bit one takes the bank from the bank select pointer
`timescale 1ns/10ps
`default_nettype none
module bcdadj_core
  import bcdadj_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire bcdadj_pkg::bcdadj_instr_t instr,
  input wire logic [7:0] acc_in,
  input wire logic [3:0] bank_select_pointer,
  input wire logic [7:0] reg_rd_data,
  input wire bcdadj_pkg::bcdadj_flags_t flags_in,
  output logic [1:0] phase,
  output logic reg_rd_en,
  output logic [11:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic acc_wr_en,
  output logic [7:0] acc_wr_data,
  output logic flags_wr_en,
  output bcdadj_pkg::bcdadj_flags_t flags_wr_mask,
  output bcdadj_pkg::bcdadj_flags_t flags_out
);
  import bcdadj_pkg::*;

  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE}
    bcdadj_phase_t;

  bcdadj_phase_t phase_reg, phase_next;
  logic active_reg, active_next;
  bcdadj_instr_t op_reg, op_next;
  logic [11:0] addr_reg, addr_next;
  logic [7:0] opnd_reg, opnd_next;
  bcdadj_flags_t fin_reg, fin_next;
  logic [7:0] res_reg, res_next;
  bcdadj_flags_t fres_reg, fres_next;
  bcdadj_flags_t mask_reg, mask_next;

  // digit fix flags stay open: the sums already carry the correction
  logic [5:0] lo_sum, hi_sum;
  logic [4:0] hi_digit;
  logic [7:0] dec_val;

  bcdadj_digit u_lo (
    .digit({1'b0, opnd_reg[3:0]}),
    .force_fix(fin_reg.dc),
    .fixed(),
    .sum(lo_sum)
  );
  // low correction carry feeds the high digit before it is tested
  assign hi_digit = {1'b0, opnd_reg[7:4]} + {4'h0, lo_sum[4]};
  bcdadj_digit u_hi (
    .digit(hi_digit),
    .force_fix(fin_reg.c),
    .fixed(),
    .sum(hi_sum)
  );
  assign dec_val = opnd_reg - 8'h01;

  always_comb
  begin
    phase_next = phase_reg;
    active_next = active_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    opnd_next = opnd_reg;
    fin_next = fin_reg;
    res_next = res_reg;
    fres_next = fres_reg;
    mask_next = mask_reg;
    unique case (phase_reg)
      PH_DECODE:
      begin
        phase_next = PH_READ;
        active_next = instr_valid;
        op_next = instr;
        if (instr.use_bank)
          addr_next = {bank_select_pointer, instr.addr};
        else if (instr.addr < WINDOW_SPLIT)
          addr_next = {WINDOW_LO_BANK, instr.addr};
        else
          addr_next = {WINDOW_HI_BANK, instr.addr};
      end
      PH_READ:
      begin
        phase_next = PH_PROCESS;
        opnd_next = (op_reg.kind == OP_BCD_ADJUST) ? acc_in : reg_rd_data;
        fin_next = flags_in;
      end
      PH_PROCESS:
      begin
        phase_next = PH_WRITE;
        fres_next = fin_reg;
        if (op_reg.kind == OP_BCD_ADJUST)
        begin
          res_next = {hi_sum[3:0], lo_sum[3:0]};
          // old carry stays set: it already stood for a decimal hundred
          fres_next.c = fin_reg.c || hi_sum[4] || hi_sum[5];
          fres_next.dc = 1'b0;
          mask_next = FLAGS_ADJUST;
        end
        else
        begin
          res_next = dec_val;
          fres_next.c = (opnd_reg != 8'h00);
          fres_next.dc = (opnd_reg[3:0] != 4'h0);
          fres_next.n = dec_val[7];
          fres_next.ov = (opnd_reg == SIGNED_MIN);
          fres_next.z = (dec_val == 8'h00);
          mask_next = FLAGS_ALL;
        end
      end
      PH_WRITE:
        phase_next = PH_DECODE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      phase_reg <= PH_DECODE;
      active_reg <= 1'b0;
      op_reg <= INSTR_RESET;
      addr_reg <= 12'h000;
      opnd_reg <= RESET_BYTE;
      fin_reg <= FLAGS_NONE;
      res_reg <= RESET_BYTE;
      fres_reg <= FLAGS_NONE;
      mask_reg <= FLAGS_NONE;
    end
    else
    begin
      phase_reg <= phase_next;
      active_reg <= active_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      opnd_reg <= opnd_next;
      fin_reg <= fin_next;
      res_reg <= res_next;
      fres_reg <= fres_next;
      mask_reg <= mask_next;
    end
  end

  logic in_write;
  logic is_dec;
  assign in_write = active_reg && (phase_reg == PH_WRITE);
  assign is_dec = (op_reg.kind == OP_MINUS_ONE);

  assign phase = phase_reg;
  assign reg_addr = addr_reg;
  assign reg_rd_en = active_reg && is_dec && (phase_reg == PH_READ);
  assign reg_wr_en = in_write && is_dec && op_reg.to_reg;
  // adjust always lands in the accumulator
  assign acc_wr_en = in_write && !(is_dec && op_reg.to_reg);
  assign reg_wr_data = res_reg;
  assign acc_wr_data = res_reg;
  assign flags_wr_en = in_write;
  assign flags_wr_mask = mask_reg;
  assign flags_out = fres_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_low_nibble_kept: assert property (
    in_write && !is_dec && opnd_reg[3:0] <= 4'h9 && !fin_reg.dc
    |-> res_reg[3:0] == opnd_reg[3:0])
    else $error("low nibble changed without cause");
  a_low_nibble_fixed: assert property (
    in_write && !is_dec && opnd_reg[3:0] > 4'h9
    |-> res_reg[3:0] == opnd_reg[3:0] + 4'h6)
    else $error("low nibble not corrected");
  a_high_nibble_fixed: assert property (
    in_write && !is_dec && opnd_reg[3:0] <= 4'h9 && !fin_reg.dc
    && (opnd_reg[7:4] > 4'h9 || fin_reg.c)
    |-> res_reg[7:4] == opnd_reg[7:4] + 4'h6)
    else $error("high nibble not corrected");
  a_adjust_carry: assert property (
    in_write && !is_dec && opnd_reg[7:4] > 4'h9 |-> flags_out.c)
    else $error("adjust did not set carry");
  a_minus_one_value: assert property (
    active_reg && is_dec && phase_reg == PH_READ
    |-> ##2 reg_wr_data == $past(reg_rd_data, 2) - 8'h01)
    else $error("decrement result wrong");
  a_dest_accumulator: assert property (
    in_write && is_dec && !op_reg.to_reg |-> acc_wr_en && !reg_wr_en)
    else $error("acc target misrouted");
  a_dest_register: assert property (
    in_write && is_dec && op_reg.to_reg |-> reg_wr_en && !acc_wr_en)
    else $error("register target misrouted");
  a_window_bank: assert property (
    phase_reg == PH_DECODE && !instr.use_bank
    |=> reg_addr[11:8] == ($past(instr.addr) < 8'h80 ? 4'h0 : 4'hf))
    else $error("window bank wrong");
  a_pointer_bank: assert property (
    phase_reg == PH_DECODE && instr.use_bank
    |=> reg_addr == {$past(bank_select_pointer), $past(instr.addr)})
    else $error("pointer bank wrong");
  a_adjust_flags: assert property (
    in_write && !is_dec |-> !flags_wr_mask.n && !flags_wr_mask.ov
    && !flags_wr_mask.z && flags_wr_mask.c && flags_wr_mask.dc)
    else $error("adjust touched other flags");
  a_dec_zero_flag: assert property (
    in_write && is_dec |-> flags_out.z == (res_reg == 8'h00)
    && flags_wr_mask == 5'h1f)
    else $error("decrement zero flag wrong");
  a_four_phases: assert property (
    phase_reg == PH_DECODE && instr_valid
    |-> ##3 (flags_wr_en && phase_reg == PH_WRITE) ##1 phase_reg == PH_DECODE)
    else $error("instruction not four phases");
endmodule // bcdadj_core
`default_nettype wire

// ### tb/bcdadj_regfile.sv
// far-side model: data registers, accumulator and flags of the core
`timescale 1ns/10ps
`default_nettype none
module bcdadj_regfile
  import bcdadj_pkg::*;
(
  input wire logic core_clk,
  input wire logic reg_rd_en,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic acc_wr_en,
  input wire logic [7:0] acc_wr_data,
  input wire logic flags_wr_en,
  input wire bcdadj_pkg::bcdadj_flags_t flags_wr_mask,
  input wire bcdadj_pkg::bcdadj_flags_t flags_out,
  output logic [7:0] acc_in,
  output logic [7:0] reg_rd_data,
  output bcdadj_pkg::bcdadj_flags_t flags_in
);
  logic [7:0] mem [0:4095];
  logic [7:0] acc_reg;
  logic [7:0] last_rd = 8'h5a;
  bcdadj_flags_t flags_reg;
  // unread data shows the inverse byte, so a late sample cannot pass
  assign reg_rd_data = reg_rd_en ? mem[reg_addr] : ~last_rd;
  assign acc_in = acc_reg;
  assign flags_in = flags_reg;
  always @(posedge core_clk)
  begin
    if (reg_rd_en)
      last_rd <= mem[reg_addr];
    if (reg_wr_en)
      mem[reg_addr] <= reg_wr_data;
    if (acc_wr_en)
      acc_reg <= acc_wr_data;
    if (flags_wr_en)
      flags_reg <= (flags_out & flags_wr_mask) |
        (flags_reg & ~flags_wr_mask);
  end
endmodule // bcdadj_regfile
`default_nettype wire

// ### tb/bcdadj_core_test.sv
// self-checking bench for the bcd adjust and minus one datapath
`timescale 1ns/10ps
`default_nettype none
module bcdadj_core_test;
  import bcdadj_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  bcdadj_instr_t instr = INSTR_RESET;
  logic [3:0] bank_select_pointer = 4'h0;
  logic [7:0] acc_in, reg_rd_data, reg_wr_data, acc_wr_data;
  bcdadj_flags_t flags_in, flags_wr_mask, flags_out;
  logic [1:0] phase;
  logic reg_rd_en, reg_wr_en, acc_wr_en, flags_wr_en;
  logic [11:0] reg_addr;
  int errors = 0;
  int checks_done = 0;

  bcdadj_core uut (.core_clk, .reset, .instr_valid, .instr, .acc_in,
    .bank_select_pointer, .reg_rd_data, .flags_in, .phase, .reg_rd_en,
    .reg_addr, .reg_wr_en, .reg_wr_data, .acc_wr_en, .acc_wr_data,
    .flags_wr_en, .flags_wr_mask, .flags_out);
  bcdadj_regfile u_far (.core_clk, .reg_rd_en, .reg_addr, .reg_wr_en,
    .reg_wr_data, .acc_wr_en, .acc_wr_data, .flags_wr_en, .flags_wr_mask,
    .flags_out, .acc_in, .reg_rd_data, .flags_in);

  initial forever #10 core_clk = ~core_clk;

  task chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1)
    begin
      $display("Error at %0t: %s", $time, m);
      errors++;
    end
  endtask

  task wrap_up;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [12:0] expect_op(input logic m,
    input logic [7:0] v, input bcdadj_flags_t f);
    logic [8:0] s;
    bcdadj_flags_t e;
    s = {1'b0, v} - 9'h001;
    e = '{n: s[7], ov: v == SIGNED_MIN, z: s[7:0] == 8'h00,
      dc: v[3:0] != 4'h0, c: v != 8'h00};
    if (!m)
    begin
      s = {1'b0, v};
      if (v[3:0] > BCD_MAX_DIGIT || f.dc)
        s = s + 9'h006;
      if (s[8:4] > 5'h09 || f.c)
        s = s + 9'h060;
      e = f;
      e.dc = 1'b0;
      e.c = f.c | s[8];
    end
    return {e, s[7:0]};
  endfunction

  task do_op(input bcdadj_kind_t k, input logic t, b, input logic [7:0] ad,
    v, input bcdadj_flags_t f, input logic [3:0] p);
    logic m;
    logic [12:0] x;
    logic [11:0] ea;
    m = (k == OP_MINUS_ONE);
    x = expect_op(m, v, f);
    ea = {b ? p : (ad < WINDOW_SPLIT ? WINDOW_LO_BANK : WINDOW_HI_BANK), ad};
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr <= '{kind: k, to_reg: t, use_bank: b, addr: ad};
    bank_select_pointer <= p;
    #1;
    u_far.flags_reg = f;
    u_far.acc_reg = m ? 8'($urandom) : v;
    u_far.mem[ea] = v;
    // junk outside decode must be ignored
    @(posedge core_clk);
    instr_valid <= 1'($urandom);
    instr <= 12'($urandom);
    bank_select_pointer <= 4'($urandom);
    @(negedge core_clk);
    chk(phase === 2'h1 && reg_rd_en === m, "read phase");
    chk(!m || reg_addr === ea, "bank address");
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({reg_wr_en, acc_wr_en} === {m & t, !(m & t)}, "dest");
    chk(acc_wr_data === x[7:0], "acc data");
    chk(reg_wr_data === x[7:0], "reg data");
    chk(flags_wr_en === 1'b1 && flags_out === x[12:8], "flags");
    chk(flags_wr_mask === (m ? FLAGS_ALL : FLAGS_ADJUST), "mask");
  endtask

  initial
  begin
    #60000;
    errors++;
    wrap_up;
  end

  initial
  begin
    void'($urandom(23));
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk({phase, reg_rd_en, reg_wr_en, acc_wr_en} === 5'h00, "reset");
    while (phase !== 2'h3)
      @(negedge core_clk);
    do_op(OP_BCD_ADJUST, 1'b1, 1'b1, 8'h00, 8'ha5, 5'h00, 4'h0);
    do_op(OP_BCD_ADJUST, 1'b0, 1'b0, 8'h00, 8'hce, 5'h00, 4'h0);
    do_op(OP_BCD_ADJUST, 1'b0, 1'b0, 8'h00, 8'h12, 5'h02, 4'h0);
    do_op(OP_BCD_ADJUST, 1'b0, 1'b0, 8'h00, 8'h12, 5'h1d, 4'h0);
    do_op(OP_BCD_ADJUST, 1'b0, 1'b0, 8'h00, 8'h99, 5'h00, 4'h0);
    do_op(OP_MINUS_ONE, 1'b1, 1'b1, 8'h7f, 8'h00, 5'h1f, 4'h5);
    do_op(OP_MINUS_ONE, 1'b0, 1'b0, 8'h7f, 8'h80, 5'h00, 4'h5);
    do_op(OP_MINUS_ONE, 1'b1, 1'b0, 8'h80, 8'h01, 5'h00, 4'h3);
    do_op(OP_MINUS_ONE, 1'b0, 1'b1, 8'hff, 8'h10, 5'h00, 4'hf);
    repeat (300)
      do_op(bcdadj_kind_t'(1'($urandom)), 1'($urandom), 1'($urandom),
        8'($urandom), 8'($urandom), 5'($urandom), 4'($urandom));
    @(posedge core_clk);
    instr_valid <= 1'b0;
    repeat (4)
    begin
      @(negedge core_clk);
      chk(flags_wr_en === 1'b0 && reg_rd_en === 1'b0, "idle");
    end
    wrap_up;
  end
endmodule // bcdadj_core_test
`default_nettype wire
